// [src/pvc_pkg.sv]
// pvc_pkg.sv: constants for contact polarity and pv colour select
// assumes a 32-bit axi4-lite register bus and 16-bit signed pv and sp
// Functional notes
// - a polarity bit of 0 closes a contact while its event is on, 1 opens it.
// - four terminal areas carry five extra contacts each, each with polarity.
// - both control relays have polarity and can act as status outputs.
// - mode 2 shows red while alarm 1 is on, mode 3 the inverse.
// - mode 4 shows red while alarm 1 or alarm 2 is on, mode 5 the inverse.
// - mode 6 is white with pv inside the limits and red outside, 7 inverse.
// - mode 8 is white with deviation inside the band and red outside, 9 inverse.
// - deviation is pv minus target setpoint, high limit upper edge, minus low limit lower edge.
// - mode 10 shows red while the chosen digital input is on, else white.
// - a source selector holds the input identifier, 5025 being input one.
// - limit and band comparisons switch at the edges with no hysteresis.
// - both colour limits are signed and held within -19999 to 30000.
package pvc_pkg;
	// ***************************************************
	// sizes
	// ***************************************************
	localparam int ADDR_W = 8;
	localparam int N_ALARM = 3;
	localparam int N_AREA = 4;
	localparam int N_PER_AREA = 5;
	localparam int N_EXTRA = N_AREA * N_PER_AREA;
	localparam int N_RELAY = 2;
	localparam int N_DI = 3;
	localparam int PV_W = 16;
	localparam int MODE_W = 4;
	localparam int POL_W = 7;
	// ***************************************************
	// register offsets
	// ***************************************************
	localparam logic [ADDR_W-1:0] ADDR_POL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_EXTRA = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_HIGH = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_LOW = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_SRC = 8'h14;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h18;
	// ***************************************************
	// field positions
	// ***************************************************
	localparam int POL_ALARM_LSB = 0;
	localparam int POL_RELAY_LSB = 3;
	localparam int USE_STAT_LSB = 5;
	localparam int STAT_RED = 0;
	localparam int STAT_DI_LSB = 1;
	localparam int STAT_ALARM_LSB = 4;
	localparam int STAT_RELAY_LSB = 7;
	// ***************************************************
	// reset values and ranges
	// ***************************************************
	localparam logic [POL_W-1:0] RST_POL = 7'h00;
	localparam logic [N_EXTRA-1:0] RST_EXTRA = 20'h00000;
	localparam logic [MODE_W-1:0] RST_MODE = 4'h0;
	localparam logic signed [PV_W-1:0] RST_HIGH = 16'sh0000;
	localparam logic signed [PV_W-1:0] RST_LOW = 16'sh0000;
	localparam logic signed [PV_W-1:0] LIMIT_MIN = 16'shb1e1;
	localparam logic signed [PV_W-1:0] LIMIT_MAX = 16'sh7530;
	localparam logic [PV_W-1:0] DI_ID_BASE = 16'h13a1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ***************************************************
	// colour modes
	// ***************************************************
	localparam logic [MODE_W-1:0] MODE_WHITE = 4'h0;
	localparam logic [MODE_W-1:0] MODE_RED = 4'h1;
	localparam logic [MODE_W-1:0] MODE_AL1 = 4'h2;
	localparam logic [MODE_W-1:0] MODE_AL1_INV = 4'h3;
	localparam logic [MODE_W-1:0] MODE_AL12 = 4'h4;
	localparam logic [MODE_W-1:0] MODE_AL12_INV = 4'h5;
	localparam logic [MODE_W-1:0] MODE_PV = 4'h6;
	localparam logic [MODE_W-1:0] MODE_PV_INV = 4'h7;
	localparam logic [MODE_W-1:0] MODE_DEV = 4'h8;
	localparam logic [MODE_W-1:0] MODE_DEV_INV = 4'h9;
	localparam logic [MODE_W-1:0] MODE_DI = 4'ha;
endpackage

// [src/pvc_top.sv]
// pvc_top.sv: contact polarity and pv colour select with axi4-lite regs
// assumes event inputs come from logic on aclk, digital inputs from pins
`timescale 1ns/100ps
`default_nettype none
module pvc_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [pvc_pkg::ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [pvc_pkg::ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic [pvc_pkg::N_ALARM-1:0] alarm_evt,
	input wire logic [pvc_pkg::N_EXTRA-1:0] extra_evt,
	input wire logic [pvc_pkg::N_RELAY-1:0] relay_ctrl,
	input wire logic [pvc_pkg::N_RELAY-1:0] relay_stat_evt,
	input wire logic signed [pvc_pkg::PV_W-1:0] pv,
	input wire logic signed [pvc_pkg::PV_W-1:0] target_sp,
	input wire logic [pvc_pkg::N_DI-1:0] di_pin,
	output logic [pvc_pkg::N_ALARM-1:0] alarm_contact,
	output logic [pvc_pkg::N_EXTRA-1:0] extra_contact,
	output logic [pvc_pkg::N_RELAY-1:0] relay_contact,
	output logic pv_red
);
	localparam int XW = pvc_pkg::PV_W + 1;

	// ***************************************************
	// functions
	// ***************************************************
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			merge[8*i +: 8] = be[i] ? wd[8*i +: 8] : old[8*i +: 8];
		end
	endfunction
	function automatic logic signed [pvc_pkg::PV_W-1:0] clamp(
		input logic signed [pvc_pkg::PV_W-1:0] v);
		clamp = (v < pvc_pkg::LIMIT_MIN) ? pvc_pkg::LIMIT_MIN
			: (v > pvc_pkg::LIMIT_MAX) ? pvc_pkg::LIMIT_MAX : v;
	endfunction
	function automatic logic in_band(input logic signed [XW-1:0] x,
		input logic signed [XW-1:0] lo, input logic signed [XW-1:0] hi);
		in_band = (x >= lo) && (x <= hi);
	endfunction
	// ***************************************************
	// register bus and registers
	// ***************************************************
	logic awready_ff, nxt_awready;
	logic wready_ff, nxt_wready;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic arready_ff, nxt_arready;
	logic rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] rresp_ff, nxt_rresp;
	logic aw_got_ff, nxt_aw_got;
	logic w_got_ff, nxt_w_got;
	logic [pvc_pkg::ADDR_W-1:0] awaddr_ff, nxt_awaddr;
	logic [31:0] wdata_ff, nxt_wdata;
	logic [3:0] wstrb_ff, nxt_wstrb;
	logic [pvc_pkg::POL_W-1:0] pol_ff, nxt_pol;
	logic [pvc_pkg::N_EXTRA-1:0] extra_pol_ff, nxt_extra_pol;
	logic [pvc_pkg::MODE_W-1:0] mode_ff, nxt_mode;
	logic signed [pvc_pkg::PV_W-1:0] high_ff, nxt_high;
	logic signed [pvc_pkg::PV_W-1:0] low_ff, nxt_low;
	logic [pvc_pkg::PV_W-1:0] src_ff, nxt_src;
	logic [pvc_pkg::N_DI-1:0] di_ff;
	logic [31:0] m, stat;
	always_comb begin
		stat = 32'h0000_0000;
		stat[pvc_pkg::STAT_RED] = pv_red;
		stat[pvc_pkg::STAT_DI_LSB +: pvc_pkg::N_DI] = di_ff;
		stat[pvc_pkg::STAT_ALARM_LSB +: pvc_pkg::N_ALARM] = alarm_contact;
		stat[pvc_pkg::STAT_RELAY_LSB +: pvc_pkg::N_RELAY] = relay_contact;
	end
	always_comb begin
		nxt_aw_got = aw_got_ff;
		nxt_w_got = w_got_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb = wstrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		nxt_pol = pol_ff;
		nxt_extra_pol = extra_pol_ff;
		nxt_mode = mode_ff;
		nxt_high = high_ff;
		nxt_low = low_ff;
		nxt_src = src_ff;
		m = 32'h0000_0000;
		if (awvalid && awready_ff) begin
			nxt_aw_got = 1'b1;
			nxt_awaddr = awaddr;
		end
		if (wvalid && wready_ff) begin
			nxt_w_got = 1'b1;
			nxt_wdata = wdata;
			nxt_wstrb = wstrb;
		end
		if (bvalid_ff && bready) begin
			nxt_bvalid = 1'b0;
		end
		if (aw_got_ff && w_got_ff && !bvalid_ff) begin
			nxt_aw_got = 1'b0;
			nxt_w_got = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = pvc_pkg::RESP_OKAY;
			case ({awaddr_ff[pvc_pkg::ADDR_W-1:2], 2'h0})
				pvc_pkg::ADDR_POL: begin
					m = merge(32'(pol_ff), wdata_ff, wstrb_ff);
					nxt_pol = m[pvc_pkg::POL_W-1:0];
				end
				pvc_pkg::ADDR_EXTRA: begin
					m = merge(32'(extra_pol_ff), wdata_ff, wstrb_ff);
					nxt_extra_pol = m[pvc_pkg::N_EXTRA-1:0];
				end
				pvc_pkg::ADDR_MODE: begin
					m = merge(32'(mode_ff), wdata_ff, wstrb_ff);
					nxt_mode = m[pvc_pkg::MODE_W-1:0];
				end
				pvc_pkg::ADDR_HIGH: begin
					m = merge(32'(high_ff), wdata_ff, wstrb_ff);
					nxt_high = clamp(m[pvc_pkg::PV_W-1:0]);
				end
				pvc_pkg::ADDR_LOW: begin
					m = merge(32'(low_ff), wdata_ff, wstrb_ff);
					nxt_low = clamp(m[pvc_pkg::PV_W-1:0]);
				end
				pvc_pkg::ADDR_SRC: begin
					m = merge(32'(src_ff), wdata_ff, wstrb_ff);
					nxt_src = m[pvc_pkg::PV_W-1:0];
				end
				pvc_pkg::ADDR_STAT: nxt_bresp = pvc_pkg::RESP_OKAY;
				default: nxt_bresp = pvc_pkg::RESP_SLVERR;
			endcase
		end
		if (arvalid && arready_ff) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = pvc_pkg::RESP_OKAY;
			case ({araddr[pvc_pkg::ADDR_W-1:2], 2'h0})
				pvc_pkg::ADDR_POL: nxt_rdata = 32'(pol_ff);
				pvc_pkg::ADDR_EXTRA: nxt_rdata = 32'(extra_pol_ff);
				pvc_pkg::ADDR_MODE: nxt_rdata = 32'(mode_ff);
				pvc_pkg::ADDR_HIGH: nxt_rdata = 32'(unsigned'(high_ff));
				pvc_pkg::ADDR_LOW: nxt_rdata = 32'(unsigned'(low_ff));
				pvc_pkg::ADDR_SRC: nxt_rdata = 32'(src_ff);
				pvc_pkg::ADDR_STAT: nxt_rdata = stat;
				default: begin
					nxt_rdata = 32'h0000_0000;
					nxt_rresp = pvc_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_ff && rready) begin
			nxt_rvalid = 1'b0;
		end
		nxt_awready = !nxt_aw_got && !nxt_bvalid;
		nxt_wready = !nxt_w_got && !nxt_bvalid;
		nxt_arready = !nxt_rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= pvc_pkg::RESP_OKAY;
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= pvc_pkg::RESP_OKAY;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= pvc_pkg::ADDR_POL;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			pol_ff <= pvc_pkg::RST_POL;
			extra_pol_ff <= pvc_pkg::RST_EXTRA;
			mode_ff <= pvc_pkg::RST_MODE;
			high_ff <= pvc_pkg::RST_HIGH;
			low_ff <= pvc_pkg::RST_LOW;
			src_ff <= pvc_pkg::DI_ID_BASE;
		end else begin
			awready_ff <= nxt_awready;
			wready_ff <= nxt_wready;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			arready_ff <= nxt_arready;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
			aw_got_ff <= nxt_aw_got;
			w_got_ff <= nxt_w_got;
			awaddr_ff <= nxt_awaddr;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			pol_ff <= nxt_pol;
			extra_pol_ff <= nxt_extra_pol;
			mode_ff <= nxt_mode;
			high_ff <= nxt_high;
			low_ff <= nxt_low;
			src_ff <= nxt_src;
		end
	end

	// ***************************************************
	// digital input synchroniser
	// ***************************************************
	logic [pvc_pkg::N_DI-1:0] di_s1_ff, di_s2_ff, di_s3_ff, nxt_di;

	always_comb begin
		for (int i = 0; i < pvc_pkg::N_DI; i++) begin
			nxt_di[i] = (di_s2_ff[i] == di_s3_ff[i]) ? di_s3_ff[i] : di_ff[i];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			di_s1_ff <= '0;
			di_s2_ff <= '0;
			di_s3_ff <= '0;
			di_ff <= '0;
		end else begin
			di_s1_ff <= di_pin;
			di_s2_ff <= di_s1_ff;
			di_s3_ff <= di_s2_ff;
			di_ff <= nxt_di;
		end
	end

	// ***************************************************
	// contacts and colour
	// ***************************************************
	logic [pvc_pkg::N_ALARM-1:0] alarm_contact_ff, nxt_alarm_contact;
	logic [pvc_pkg::N_EXTRA-1:0] extra_contact_ff, nxt_extra_contact;
	logic [pvc_pkg::N_RELAY-1:0] relay_contact_ff, nxt_relay_contact;
	logic [pvc_pkg::N_RELAY-1:0] relay_src;
	logic pv_red_ff, nxt_pv_red;
	logic signed [XW-1:0] pv_x, dev, hi_x, lo_x;
	logic pv_in, dev_in, di_sel;
	logic [pvc_pkg::PV_W-1:0] di_idx;

	always_comb begin
		relay_src = (pol_ff[pvc_pkg::USE_STAT_LSB +: pvc_pkg::N_RELAY]
			& relay_stat_evt)
			| (~pol_ff[pvc_pkg::USE_STAT_LSB +: pvc_pkg::N_RELAY]
			& relay_ctrl);
		nxt_alarm_contact = alarm_evt
			^ pol_ff[pvc_pkg::POL_ALARM_LSB +: pvc_pkg::N_ALARM];
		nxt_extra_contact = extra_evt ^ extra_pol_ff;
		nxt_relay_contact = relay_src
			^ pol_ff[pvc_pkg::POL_RELAY_LSB +: pvc_pkg::N_RELAY];
		pv_x = XW'(pv);
		hi_x = XW'(high_ff);
		lo_x = XW'(low_ff);
		dev = pv_x - XW'(target_sp);
		pv_in = in_band(pv_x, lo_x, hi_x);
		dev_in = in_band(dev, -lo_x, hi_x);
		di_idx = src_ff - pvc_pkg::DI_ID_BASE;
		di_sel = 1'b0;
		if (src_ff >= pvc_pkg::DI_ID_BASE
			&& di_idx < pvc_pkg::PV_W'(pvc_pkg::N_DI)) begin
			di_sel = di_ff[di_idx[1:0]];
		end
		case (mode_ff)
			pvc_pkg::MODE_WHITE: nxt_pv_red = 1'b0;
			pvc_pkg::MODE_RED: nxt_pv_red = 1'b1;
			pvc_pkg::MODE_AL1: nxt_pv_red = alarm_evt[0];
			pvc_pkg::MODE_AL1_INV: nxt_pv_red = !alarm_evt[0];
			pvc_pkg::MODE_AL12: nxt_pv_red = |alarm_evt[1:0];
			pvc_pkg::MODE_AL12_INV: nxt_pv_red = !(|alarm_evt[1:0]);
			pvc_pkg::MODE_PV: nxt_pv_red = !pv_in;
			pvc_pkg::MODE_PV_INV: nxt_pv_red = pv_in;
			pvc_pkg::MODE_DEV: nxt_pv_red = !dev_in;
			pvc_pkg::MODE_DEV_INV: nxt_pv_red = dev_in;
			pvc_pkg::MODE_DI: nxt_pv_red = di_sel;
			default: nxt_pv_red = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alarm_contact_ff <= '0;
			extra_contact_ff <= '0;
			relay_contact_ff <= '0;
			pv_red_ff <= 1'b0;
		end else begin
			alarm_contact_ff <= nxt_alarm_contact;
			extra_contact_ff <= nxt_extra_contact;
			relay_contact_ff <= nxt_relay_contact;
			pv_red_ff <= nxt_pv_red;
		end
	end

	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign alarm_contact = alarm_contact_ff;
	assign extra_contact = extra_contact_ff;
	assign relay_contact = relay_contact_ff;
	assign pv_red = pv_red_ff;
endmodule
`default_nettype wire

// [verif/pvc_top_props.sv]
// pvc_top_props.sv: assertions on the contact and colour outputs
// assumes full-word mode and limit writes, inputs driven on aclk
`timescale 1ns/100ps
`default_nettype none
module pvc_top_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [pvc_pkg::ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [31:0] wdata,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [pvc_pkg::N_ALARM-1:0] alarm_evt,
	input wire logic [pvc_pkg::N_EXTRA-1:0] extra_evt,
	input wire logic [pvc_pkg::N_RELAY-1:0] relay_ctrl,
	input wire logic [pvc_pkg::N_RELAY-1:0] relay_stat_evt,
	input wire logic signed [pvc_pkg::PV_W-1:0] pv,
	input wire logic signed [pvc_pkg::PV_W-1:0] target_sp,
	input wire logic [pvc_pkg::N_ALARM-1:0] alarm_contact,
	input wire logic [pvc_pkg::N_EXTRA-1:0] extra_contact,
	input wire logic [pvc_pkg::N_RELAY-1:0] relay_contact,
	input wire logic pv_red
);
	// ********************
	// shadow of mode and limits
	// ********************
	logic [1:0] q_ff;
	logic [7:0] a_ff;
	logic [31:0] d_ff;
	logic [3:0] md_ff;
	int hi_ff;
	int lo_ff;
	int dv;
	logic ok;
	logic red_c;
	function automatic int clamp(input logic [15:0] v);
		int s;
		s = int'($signed(v));
		if (s < int'(pvc_pkg::LIMIT_MIN))
			s = int'(pvc_pkg::LIMIT_MIN);
		if (s > int'(pvc_pkg::LIMIT_MAX))
			s = int'(pvc_pkg::LIMIT_MAX);
		return s;
	endfunction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q_ff <= 2'h0;
			md_ff <= 4'h0;
			hi_ff <= 0;
			lo_ff <= 0;
		end else begin
			q_ff <= bvalid ? 2'h0 : (q_ff == 2'h3 ? q_ff : q_ff + 2'h1);
			if (awvalid && awready)
				a_ff <= awaddr;
			if (wvalid && wready)
				d_ff <= wdata;
			if (bvalid && bready && a_ff == pvc_pkg::ADDR_MODE)
				md_ff <= d_ff[3:0];
			if (bvalid && bready && a_ff == pvc_pkg::ADDR_HIGH)
				hi_ff <= clamp(d_ff[15:0]);
			if (bvalid && bready && a_ff == pvc_pkg::ADDR_LOW)
				lo_ff <= clamp(d_ff[15:0]);
		end
	end
	always_comb begin
		ok = q_ff == 2'h3;
		dv = int'(pv) - int'(target_sp);
		case (md_ff)
			4'h0, 4'h1: red_c = 1'b0;
			4'h2, 4'h3: red_c = alarm_evt[0];
			4'h4, 4'h5: red_c = alarm_evt[0] | alarm_evt[1];
			4'h6, 4'h7: red_c = int'(pv) < lo_ff || int'(pv) > hi_ff;
			default: red_c = dv < -lo_ff || dv > hi_ff;
		endcase
		red_c = red_c ^ md_ff[0];
	end
	// ********************
	// assertions
	// ********************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_ALARM_POL: assert property (ok |->
		(alarm_contact ^ $past(alarm_contact)) ==
		($past(alarm_evt) ^ $past(alarm_evt, 2)))
		else $error("alarm contact did not follow its event");
	AST_EXTRA_POL: assert property (ok |->
		(extra_contact ^ $past(extra_contact)) ==
		($past(extra_evt) ^ $past(extra_evt, 2)))
		else $error("extra contact did not follow its event");
	AST_RELAY_HOLD: assert property (ok &&
		$past(relay_ctrl) == $past(relay_ctrl, 2) &&
		$past(relay_stat_evt) == $past(relay_stat_evt, 2)
		|-> $stable(relay_contact))
		else $error("relay contact moved with no cause");
	AST_FIXED: assert property (ok && md_ff <= 4'h1 |->
		pv_red == md_ff[0]) else $error("fixed colour wrong");
	AST_AL1: assert property (ok && md_ff inside {4'h2, 4'h3} |->
		pv_red == $past(red_c)) else $error("alarm 1 colour wrong");
	AST_AL12: assert property (ok && md_ff inside {4'h4, 4'h5} |->
		pv_red == $past(red_c)) else $error("alarm 1 or 2 colour wrong");
	AST_PV_WIN: assert property (ok && md_ff inside {4'h6, 4'h7} |->
		pv_red == $past(red_c)) else $error("pv window colour wrong");
	AST_DEV: assert property (ok && md_ff inside {4'h8, 4'h9} |->
		pv_red == $past(red_c)) else $error("deviation colour wrong");
	cover property (ok && md_ff == 4'h8 && pv_red);
	cover property (ok && md_ff == 4'h6 && !pv_red);
	cover property (ok && md_ff == 4'ha && pv_red);
endmodule
bind pvc_top pvc_top_props i_props (.aclk, .aresetn, .awvalid, .awready,
	.awaddr, .wvalid, .wready, .wdata, .bvalid, .bready, .alarm_evt,
	.extra_evt, .relay_ctrl, .relay_stat_evt, .pv, .target_sp,
	.alarm_contact, .extra_contact, .relay_contact, .pv_red);
`default_nettype wire

// [verif/testbench.sv]
// testbench.sv: self-checking bench for pvc_top
// assumes the package is compiled first and the checker is bound
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, hw, lw;
	logic [3:0] wstrb = 4'hf;
	logic [2:0] alarm_evt = 3'h0, di_pin = 3'h0, alarm_contact;
	logic [19:0] extra_evt = 20'h0, extra_contact;
	logic [1:0] relay_ctrl = 2'h0, relay_stat_evt = 2'h0, relay_contact;
	logic [1:0] bresp, rresp, rl;
	logic signed [15:0] pv = 16'sh0, target_sp = 16'sh0;
	logic awready, wready, bvalid, arready, rvalid, pv_red, red;
	int miscompares = 0, checks_done = 0, cycles = 0;
	int pol, ext, md, hi, lo, src, ps, ss;
	pvc_top i_pvc_top (.aclk, .aresetn, .awvalid, .awready, .awaddr,
		.wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
		.arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
		.alarm_evt, .extra_evt, .relay_ctrl, .relay_stat_evt, .pv,
		.target_sp, .di_pin, .alarm_contact, .extra_contact,
		.relay_contact, .pv_red);
	always #50 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	// ********************
	// checks, bus tasks, model
	// ********************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (miscompares == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk(bresp, (a > 8'h18) ? 2'h2 : 2'h0);
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk(rdata, ed);
		chk(rresp, (a > 8'h18) ? 2'h2 : 2'h0);
		@(posedge aclk);
	endtask
	function automatic int clamp(input logic [15:0] v);
		int s;
		s = int'($signed(v));
		s = s < int'(pvc_pkg::LIMIT_MIN) ? int'(pvc_pkg::LIMIT_MIN) : s;
		return s > int'(pvc_pkg::LIMIT_MAX) ? int'(pvc_pkg::LIMIT_MAX) : s;
	endfunction
	function automatic logic red_m(input int m, input int p, input int s);
		logic o;
		int k;
		k = src - int'(pvc_pkg::DI_ID_BASE);
		case (m)
			0, 1: o = 1'b0;
			2, 3: o = alarm_evt[0];
			4, 5: o = alarm_evt[0] | alarm_evt[1];
			6, 7: o = p < lo || p > hi;
			8, 9: o = p - s < -lo || p - s > hi;
			10: o = (k inside {0, 1, 2}) ? di_pin[k] : 1'b0;
			default: return 1'b0;
		endcase
		return (m == 10) ? o : o ^ m[0];
	endfunction
	// ********************
	// main sequence
	// ********************
	initial begin
		void'($urandom(32'he608));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(pvc_pkg::ADDR_POL, 32'h0);
		rd(pvc_pkg::ADDR_MODE, 32'h0);
		rd(pvc_pkg::ADDR_HIGH, 32'h0);
		rd(pvc_pkg::ADDR_SRC, 32'(pvc_pkg::DI_ID_BASE));
		rd(8'h1c, 32'h0);
		wr(8'h1c, 32'h1);
		wr(pvc_pkg::ADDR_STAT, 32'h1ff);
		wstrb <= 4'h1;
		wr(pvc_pkg::ADDR_SRC, 32'h0000_00a2);
		rd(pvc_pkg::ADDR_SRC, {16'h0, pvc_pkg::DI_ID_BASE[15:8], 8'ha2});
		wstrb <= 4'hf;
		for (int i = 0; i < 64; i++) begin
			md = i % 16;
			pol = $urandom;
			ext = $urandom;
			src = int'(pvc_pkg::DI_ID_BASE) - 1 + int'($urandom % 5);
			hw = (i % 8 == 7) ? $urandom : ($urandom % 81) - 32'd40;
			lw = (i % 8 == 3) ? $urandom : ($urandom % 81) - 32'd40;
			hi = clamp(hw[15:0]);
			lo = clamp(lw[15:0]);
			ss = int'($urandom % 41) - 20;
			ps = (i % 4 == 0) ? hi : (i % 4 == 1) ? ss + hi : ss - lo;
			ps = (i % 8 == 6) ? int'($urandom % 101) - 50 : ps;
			wr(pvc_pkg::ADDR_POL, pol);
			wr(pvc_pkg::ADDR_EXTRA, ext);
			wr(pvc_pkg::ADDR_MODE, md);
			wr(pvc_pkg::ADDR_HIGH, hw);
			wr(pvc_pkg::ADDR_LOW, lw);
			wr(pvc_pkg::ADDR_SRC, src);
			alarm_evt <= 3'($urandom);
			extra_evt <= 20'($urandom);
			relay_ctrl <= 2'($urandom);
			relay_stat_evt <= 2'($urandom);
			di_pin <= 3'($urandom);
			pv <= 16'(ps);
			target_sp <= 16'(ss);
			repeat (8) @(posedge aclk);
			rl = (2'(pol >> 5) & relay_stat_evt | ~2'(pol >> 5) & relay_ctrl)
				^ 2'(pol >> 3);
			red = red_m(md, ps, ss);
			chk(alarm_contact, alarm_evt ^ 3'(pol));
			chk(extra_contact, extra_evt ^ 20'(ext));
			chk(relay_contact, rl);
			chk(pv_red, red);
			rd(pvc_pkg::ADDR_STAT, {23'h0, rl, alarm_evt ^ 3'(pol), di_pin, red});
			rd(pvc_pkg::ADDR_HIGH, 32'(hi) & 32'hffff);
			rd(pvc_pkg::ADDR_LOW, 32'(lo) & 32'hffff);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
